/* File: include/acqsf_consts.vh */
// Offsets, bit positions and reset values of the acquisition status flags block.
`ifndef ACQSF_CONSTS_VH
`define ACQSF_CONSTS_VH
`define ACQSF_ADDR_W 2
`define ACQSF_OFS_STATUS 2'h0
`define ACQSF_OFS_CTRL 2'h1
`define ACQSF_OFS_CLEAR 2'h2
`define ACQSF_BIT_EXT_TRIG 6
`define ACQSF_BIT_GATE 5
`define ACQSF_BIT_TIMER 3
`define ACQSF_BIT_OVERFLOW 2
`define ACQSF_BIT_OVERRUN 1
`define ACQSF_BIT_DATA_AVAIL_FLAG 0
`define ACQSF_BIT_SPARE_HI 7
`define ACQSF_BIT_SPARE_LO 4
`define ACQSF_CTRL_IRQ_EN 0
`define ACQSF_CTRL_POSTTRIG 1
`define ACQSF_CLR_AI 0
`define ACQSF_CLR_TIMER 1
`define ACQSF_CTRL_RESET 2'h0
`define ACQSF_SYNC_RESET 3'h4
`define ACQSF_STATUS_RESET 8'h00
`define ACQSF_UNMAPPED_DATA 32'h0000_0000
`endif

/* File: verilog/acqsf_status_flags.v */
// Acquisition status flags with an Avalon-MM register slave.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "acqsf_consts.vh"
module acqsf_status_flags (
	// Clock and reset.
	input wire i_core_clk,
	input wire i_srst,
	// Avalon-MM slave.
	input wire [`ACQSF_ADDR_W-1:0] i_avs_address,
	input wire i_avs_read,
	input wire i_avs_write,
	input wire [31:0] i_avs_writedata,
	output reg [31:0] o_avs_readdata,
	output reg o_avs_waitrequest,
	// Pins from outside the clock domain.
	input wire i_external_trigger_in,
	input wire i_acq_gate_in,
	input wire i_external_update_strobe_n,
	// Same-domain converter, counter and FIFO signals.
	input wire i_counter_a2_out,
	input wire i_counter_a0_enabled,
	input wire i_convert_cmd,
	input wire i_adc_busy,
	input wire i_fifo_write,
	input wire i_fifo_full,
	input wire i_fifo_empty,
	// Outputs.
	output reg o_convert_enable,
	output reg o_timer_event_irq,
	output reg [7:0] o_acquisition_status_word
);

	// Synchroniser index of each pin input.
	localparam SYNC_TRIG = 0;
	localparam SYNC_GATE = 1;
	localparam SYNC_UPD = 2;
	localparam SYNC_W = 3;
	localparam [SYNC_W-1:0] SYNC_RST = `ACQSF_SYNC_RESET;
	// Bus slave states.
	localparam AV_IDLE = 1'h0;
	localparam AV_ACK = 1'h1;

	wire [SYNC_W-1:0] pin_raw;
	wire [SYNC_W-1:0] pin_sync;
	reg trig_prev_ff;
	reg upd_n_prev_ff;
	reg a2_prev_ff;
	reg ext_trigger_seen_flag_ff;
	reg timer_event_flag_ff;
	reg overflow_flag_ff;
	reg overrun_flag_ff;
	reg [1:0] ctrl_ff;
	reg av_state_ff;
	reg nxt_av_state;
	reg [31:0] nxt_readdata;
	wire trig_s;
	wire gate_level_flag;
	wire upd_n_s;
	wire av_req;
	wire wr_take;
	wire clr_ai;
	wire clr_tmr;
	wire trig_rise;
	wire a2_rise;
	wire upd_rise;
	wire tmr_rise;
	wire ovf_event;
	wire ovr_event;
	wire [7:0] nxt_status;

	// Pin levels, request decoding and event detection.
	assign pin_raw = {i_external_update_strobe_n, i_acq_gate_in, i_external_trigger_in};
	assign trig_s = pin_sync[SYNC_TRIG];
	assign gate_level_flag = pin_sync[SYNC_GATE];
	assign upd_n_s = pin_sync[SYNC_UPD];
	assign av_req = i_avs_read | i_avs_write;
	assign wr_take = i_avs_write && (av_state_ff == AV_ACK);
	assign clr_ai = wr_take && (i_avs_address == `ACQSF_OFS_CLEAR) && i_avs_writedata[`ACQSF_CLR_AI];
	assign clr_tmr = wr_take && (i_avs_address == `ACQSF_OFS_CLEAR) && i_avs_writedata[`ACQSF_CLR_TIMER];
	assign trig_rise = trig_s & ~trig_prev_ff;
	assign a2_rise = i_counter_a2_out & ~a2_prev_ff;
	assign upd_rise = upd_n_s & ~upd_n_prev_ff;
	assign tmr_rise = a2_rise | upd_rise;
	assign ovf_event = i_fifo_write & i_fifo_full;
	assign ovr_event = i_convert_cmd & i_adc_busy;

	// Two-stage synchroniser per pin input; the strobe idles high, the others low.
	genvar gi;
	generate
		for (gi = 0; gi < SYNC_W; gi = gi + 1) begin : g_sync
			reg sync1_ff;
			reg sync2_ff;
			always @(posedge i_core_clk) begin
				if (i_srst) begin
					sync1_ff <= SYNC_RST[gi];
					sync2_ff <= SYNC_RST[gi];
				end else begin
					sync1_ff <= pin_raw[gi];
					sync2_ff <= sync1_ff;
				end
			end
			assign pin_sync[gi] = sync2_ff;
		end
	endgenerate

	// Previous levels for edge detection; reset loads the trigger and strobe idle levels and the live counter A2 level.
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			trig_prev_ff <= 1'h0;
			upd_n_prev_ff <= 1'h1;
			a2_prev_ff <= i_counter_a2_out;
		end else begin
			trig_prev_ff <= trig_s;
			upd_n_prev_ff <= upd_n_s;
			a2_prev_ff <= i_counter_a2_out;
		end
	end

	// External trigger seen; a set in the clearing cycle wins.
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			ext_trigger_seen_flag_ff <= 1'h0;
		end else if (ctrl_ff[`ACQSF_CTRL_POSTTRIG] && trig_rise) begin
			ext_trigger_seen_flag_ff <= 1'h1;
		end else if (clr_ai) begin
			ext_trigger_seen_flag_ff <= 1'h0;
		end
	end

	// Timer event; a set in the clearing cycle wins.
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			timer_event_flag_ff <= 1'h0;
		end else if (tmr_rise) begin
			timer_event_flag_ff <= 1'h1;
		end else if (clr_tmr) begin
			timer_event_flag_ff <= 1'h0;
		end
	end

	// Overflow; a set in the clearing cycle wins.
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			overflow_flag_ff <= 1'h0;
		end else if (ovf_event) begin
			overflow_flag_ff <= 1'h1;
		end else if (clr_ai) begin
			overflow_flag_ff <= 1'h0;
		end
	end

	// Overrun; a set in the clearing cycle wins.
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			overrun_flag_ff <= 1'h0;
		end else if (ovr_event) begin
			overrun_flag_ff <= 1'h1;
		end else if (clr_ai) begin
			overrun_flag_ff <= 1'h0;
		end
	end

	// Status word bits; the spare positions read zero.
	assign nxt_status[`ACQSF_BIT_SPARE_HI] = 1'h0;
	assign nxt_status[`ACQSF_BIT_EXT_TRIG] = ext_trigger_seen_flag_ff;
	assign nxt_status[`ACQSF_BIT_GATE] = gate_level_flag;
	assign nxt_status[`ACQSF_BIT_SPARE_LO] = 1'h0;
	assign nxt_status[`ACQSF_BIT_TIMER] = timer_event_flag_ff;
	assign nxt_status[`ACQSF_BIT_OVERFLOW] = overflow_flag_ff;
	assign nxt_status[`ACQSF_BIT_OVERRUN] = overrun_flag_ff;
	assign nxt_status[`ACQSF_BIT_DATA_AVAIL_FLAG] = ~i_fifo_empty;

	// Registered outputs derived from flags and gate level.
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			o_convert_enable <= 1'h0;
			o_timer_event_irq <= 1'h0;
			o_acquisition_status_word <= `ACQSF_STATUS_RESET;
		end else begin
			o_convert_enable <= gate_level_flag & i_counter_a0_enabled;
			o_timer_event_irq <= timer_event_flag_ff & ctrl_ff[`ACQSF_CTRL_IRQ_EN];
			o_acquisition_status_word <= nxt_status;
		end
	end

	// Read data selected by the word address.
	always @* begin
		nxt_readdata = `ACQSF_UNMAPPED_DATA;
		case (i_avs_address)
			`ACQSF_OFS_STATUS: begin
				nxt_readdata = {24'h00_0000, nxt_status};
			end
			`ACQSF_OFS_CTRL: begin
				nxt_readdata = {30'h0000_0000, ctrl_ff};
			end
			default: begin
				nxt_readdata = `ACQSF_UNMAPPED_DATA;
			end
		endcase
	end

	// Next state: one wait cycle per request, then one cycle with waitrequest low.
	always @* begin
		nxt_av_state = AV_IDLE;
		case (av_state_ff)
			AV_IDLE: begin
				if (av_req) begin
					nxt_av_state = AV_ACK;
				end
			end
			AV_ACK: begin
				nxt_av_state = AV_IDLE;
			end
			default: begin
				nxt_av_state = AV_IDLE;
			end
		endcase
	end

	// Bus slave registers; a write takes effect in the cycle waitrequest is low.
	always @(posedge i_core_clk) begin
		if (i_srst) begin
			av_state_ff <= AV_IDLE;
			o_avs_waitrequest <= 1'h1;
			o_avs_readdata <= 32'h0000_0000;
			ctrl_ff <= `ACQSF_CTRL_RESET;
		end else begin
			av_state_ff <= nxt_av_state;
			o_avs_waitrequest <= (nxt_av_state != AV_ACK);
			if ((av_state_ff == AV_IDLE) && i_avs_read) begin
				o_avs_readdata <= nxt_readdata;
			end
			if (wr_take && (i_avs_address == `ACQSF_OFS_CTRL)) begin
				ctrl_ff <= i_avs_writedata[1:0];
			end
		end
	end

endmodule // acqsf_status_flags

/* File: tb/acqsf_status_flags_properties.sv */
// Assertions on the acquisition status flags ports.
`timescale 1ns/1ps
module acqsf_status_flags_properties (
	// Inputs.
	input wire i_core_clk,
	input wire i_srst,
	input wire i_avs_write,
	input wire i_counter_a2_out,
	input wire i_convert_cmd,
	input wire i_adc_busy,
	input wire i_fifo_write,
	input wire i_fifo_full,
	input wire i_fifo_empty,
	// Outputs.
	input wire o_convert_enable,
	input wire o_timer_event_irq,
	input wire [7:0] o_acquisition_status_word
);
	wire [7:0] s = o_acquisition_status_word;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_srst);
	gate_enable_a: assert property (o_convert_enable |-> s[5]) else $error("enable off gate");
	irq_flag_a: assert property (o_timer_event_irq |-> s[3]) else $error("irq off flag");
	timer_set_a: assert property ($rose(i_counter_a2_out) |-> ##[1:2] s[3]) else $error("timer");
	overflow_set_a: assert property (i_fifo_write && i_fifo_full |-> ##[1:2] s[2]) else $error("overflow");
	overrun_set_a: assert property (i_convert_cmd && i_adc_busy |-> ##[1:2] s[1]) else $error("overrun");
	data_avail_a: assert property (!i_fifo_empty [*3] |-> s[0]) else $error("data avail");
	spare_bits_a: assert property (s[7] == 1'b0 && s[4] == 1'b0) else $error("spare bits");
	error_hold_a: assert property (!i_avs_write [*5] ##0 s[1] |=> s[1]) else $error("overrun lost");
endmodule // acqsf_status_flags_properties

/* File: tb/tb_acqsf_status_flags.sv */
// Self-checking bench of the acquisition status flags.
`timescale 1ns/1ps
module tb_acqsf_status_flags;
	reg clk = 0, rst = 1, rd = 0, wr = 0, tg = 0, gt = 0, up = 1, a2 = 0, cv = 0, bz = 0, fw = 0, fl = 0, em = 1, a0 = 1;
	reg [1:0] ad = 2'h0;
	reg [31:0] wd = 32'h0000_0000, q;
	wire [31:0] rq;
	wire wq, ce, irq;
	wire [7:0] sw;
	integer err_count = 0, tests_run = 0, n;
	acqsf_status_flags i_acqsf_status_flags (.i_core_clk(clk), .i_srst(rst), .i_avs_address(ad), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rq), .o_avs_waitrequest(wq), .i_external_trigger_in(tg),
		.i_acq_gate_in(gt), .i_external_update_strobe_n(up), .i_counter_a2_out(a2), .i_counter_a0_enabled(a0),
		.i_convert_cmd(cv), .i_adc_busy(bz), .i_fifo_write(fw), .i_fifo_full(fl), .i_fifo_empty(em),
		.o_convert_enable(ce), .o_timer_event_irq(irq), .o_acquisition_status_word(sw));
	initial forever #25 clk = ~clk;
	task conclude; begin
		$display("%0d checks, %0d errors", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	end endtask
	task chk(input [7:0] s, input [7:0] e); begin
		tests_run = tests_run + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("unexpected at %0t: %h not %h", $time, s, e);
		end
	end endtask
	task w(input integer k); repeat (k) @(posedge clk); endtask
	task bus(input [1:0] a, input d, input [7:0] v); begin
		ad <= a; rd <= !d; wr <= d; wd <= {24'h00_0000, v}; n = 0;
		@(posedge clk);
		while (wq !== 1'b0 && n < 20) begin
			@(posedge clk); n = n + 1;
		end
		if (wq !== 1'b0) begin
			err_count = err_count + 1;
			$display("unexpected at %0t: bus timeout", $time);
			conclude;
		end
		q = rq; rd <= 0; wr <= 0; @(posedge clk);
	end endtask
	task t_gate; begin
		gt <= 1; w(5); chk(sw, 8'h20); chk(ce, 1);
		a0 <= 0; w(2); chk(ce, 0); chk(sw, 8'h20); a0 <= 1;
		gt <= 0; w(5); chk({sw[5], ce}, 0);
		$display("gate done");
	end endtask
	task t_timer; begin
		bus(1, 1, 8'h01); bus(1, 0, 0); chk(q[7:0], 8'h01);
		a2 <= 1; w(3); chk(sw, 8'h08); chk(irq, 1);
		a2 <= 0; bus(0, 0, 0); chk(q[7:0], 8'h08); chk(sw, 8'h08);
		bus(1, 1, 8'h00); w(1); chk(irq, 0); bus(1, 1, 8'h01);
		bus(2, 1, 8'h02); w(2); chk(sw, 8'h00); chk(irq, 0);
		up <= 0; w(6); chk(sw, 8'h00); up <= 1; w(6); chk(sw, 8'h08); bus(2, 1, 8'h02);
		$display("timer done");
	end endtask
	task t_errs; begin
		fl <= 1; fw <= 1; bz <= 1; cv <= 1; w(1); fw <= 0; cv <= 0; w(3); chk(sw, 8'h06);
		em <= 0; bus(1, 1, 8'h02); tg <= 1; w(6); chk(sw, 8'h47);
		bus(3, 0, 0); chk(q[7:0], 8'h00); bus(3, 1, 8'hff);
		bus(2, 1, 8'h01); w(2); chk(sw, 8'h01);
		$display("errors done");
	end endtask
	initial begin
		w(3); rst <= 0;
		t_gate; t_timer; t_errs; conclude;
	end
endmodule // tb_acqsf_status_flags
bind acqsf_status_flags acqsf_status_flags_properties i_acqsf_status_flags_properties (.*);
